// File: logic/fault_status_params.svh
// constants for the fault and event status readback bank
// assumes an 8-bit register port with 7-bit addresses
// ------------------------------------------------------------
// Overview of operation
// ------------------------------------------------------------
// Overview of operation
// - latched reg two bit 7 upper, bit 6 lower analog threshold fault, self clearing
// - latched reg two bit 5 voice power-up, bit 4 voice power-down, self clearing
// - live reg zero bit 7 clock error, bit 6 pll lock
// - summary bit 5 any channel 1 fault, bit 4 any channel 2 fault
// - channel 1 faults: shorts on bits 7,6, virtual ground on bits 5,4
// - channel 2 faults use the same layout on bits 7 to 4
// - channel 2 fault register bit 0 shows live regulator short
// - live reg one bit 3 insert, bit 2 remove, bit 1 hook button
// - live reg two shows threshold and voice conditions on bits 7 to 4
// - all status bits read-only; writes change no flag
// - reserved bits read zero; host writes zero there
// - after reset every status register reads zero
// - latched reg one holds headset insert, remove, hook on bits 3 to 1
`ifndef FAULT_STATUS_PARAMS_SVH
`define FAULT_STATUS_PARAMS_SVH
`define ADDR_LATCHED_ONE 7'h3a
`define ADDR_LATCHED_TWO 7'h3b
`define ADDR_LIVE_ZERO 7'h3c
`define ADDR_CHAN_SUMMARY 7'h3d
`define ADDR_OUT_ONE 7'h40
`define ADDR_OUT_TWO 7'h41
`define ADDR_LIVE_ONE 7'h42
`define ADDR_LIVE_TWO 7'h43
`define STATUS_RESET 8'h00
`endif

// File: logic/fault_status_pkg.sv
// types for the fault and event status readback bank
// assumes nothing beyond the params header
package fault_status_pkg;
  // per-channel output fault sources
  typedef struct packed {
    logic short_pos;
    logic short_neg;
    logic vground_pos;
    logic vground_neg;
  } chan_fault_t;
  // event sources
  typedef struct packed {
    logic thresh_upper;
    logic thresh_lower;
    logic voice_up;
    logic voice_down;
    logic clock_error;
    logic pll_lock;
    logic headset_insert;
    logic headset_remove;
    logic headset_hook;
    logic regulator_short;
  } event_src_t;
  // register port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// File: logic/input_sync.sv
// three-stage synchroniser for a vector of pin-level inputs
// assumes sources are asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module input_sync
  import fault_status_pkg::*;
#(
  parameter int WIDTH = 18
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // async in, filtered out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1, stage2, stage3;
  logic [WIDTH-1:0] next_out;
  // output changes only where stages two and three agree
  always_comb begin
    next_out = sync_out;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_out[i] = stage3[i];
      end
    end
  end
  // stage one feeds stage two, stage two feeds stage three
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_out <= next_out;
    end
  end
endmodule // input_sync
`default_nettype wire

// File: logic/sticky_flags.sv
// self-clearing latched flag byte
// assumes set and clear come from the clock domain
`timescale 1ns/1ps
`default_nettype none
`include "fault_status_params.svh"
module sticky_flags
  import fault_status_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // set by condition, cleared by a read
  input wire logic [7:0] set_bits,
  input wire logic clear,
  output logic [7:0] flags
);
  logic [7:0] next_flags;
  // set wins over clear so a coincident event is kept
  always_comb begin
    next_flags = flags;
    if (clear) begin
      next_flags = 8'h00;
    end
    next_flags = next_flags | set_bits;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flags <= `STATUS_RESET;
    end else begin
      flags <= next_flags;
    end
  end
endmodule // sticky_flags
`default_nettype wire

// File: logic/fault_event_status_readback.sv
// fault and event status readback bank, latched and live views
// assumes a register port with one-cycle rd/wr strobes; sources are pins
`timescale 1ns/1ps
`default_nettype none
`include "fault_status_params.svh"
module fault_event_status_readback
  import fault_status_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // condition sources from analog and clock blocks
  input wire event_src_t events,
  input wire chan_fault_t chan_one,
  input wire chan_fault_t chan_two,
  // register port
  input wire reg_req_t req,
  output logic [7:0] rdata,
  output logic rvalid
);
  localparam int NSRC = 18;

  // ------------------------------------------------------------
  // synchronise source pins
  // ------------------------------------------------------------
  logic [NSRC-1:0] raw, syn;
  event_src_t ev;
  chan_fault_t c1, c2;
  assign raw = {events, chan_one, chan_two};
  input_sync #(.WIDTH(NSRC)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(raw),
    .sync_out(syn)
  );
  assign ev = syn[17:8];
  assign c1 = syn[7:4];
  assign c2 = syn[3:0];

  // ------------------------------------------------------------
  // live views, combinational from synchronised sources
  // ------------------------------------------------------------
  logic [7:0] live_zero, live_summary, live_out_one, live_out_two;
  logic [7:0] live_one, live_two;
  // reserved positions fixed at zero
  always_comb begin
    live_zero = {ev.clock_error, ev.pll_lock, 6'h00};
    live_summary = {2'h0, |c1, |c2, 4'h0};
    live_out_one = {c1, 4'h0};
    live_out_two = {c2, 3'h0, ev.regulator_short};
    live_one = {4'h0, ev.headset_insert, ev.headset_remove, ev.headset_hook, 1'b0};
    live_two = {ev.thresh_upper, ev.thresh_lower, ev.voice_up, ev.voice_down, 4'h0};
  end

  // ------------------------------------------------------------
  // latched flags, cleared by reading their register
  // ------------------------------------------------------------
  logic [7:0] latched_one, latched_two;
  logic clr_one, clr_two;
  assign clr_one = req.rd && (req.addr == `ADDR_LATCHED_ONE);
  assign clr_two = req.rd && (req.addr == `ADDR_LATCHED_TWO);
  // set follows the live level; a lingering condition re-sets after read
  sticky_flags u_latch_one (
    .clock(clock),
    .rst_n(rst_n),
    .set_bits(live_one & 8'h0e),
    .clear(clr_one),
    .flags(latched_one)
  );
  sticky_flags u_latch_two (
    .clock(clock),
    .rst_n(rst_n),
    .set_bits(live_two & 8'hf0),
    .clear(clr_two),
    .flags(latched_two)
  );

  // ------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------
  function automatic logic [7:0] pick(input logic [6:0] a, input logic [7:0] l1,
      input logic [7:0] l2, input logic [7:0] z, input logic [7:0] s,
      input logic [7:0] o1, input logic [7:0] o2, input logic [7:0] v1,
      input logic [7:0] v2);
    case (a)
      `ADDR_LATCHED_ONE: pick = l1;
      `ADDR_LATCHED_TWO: pick = l2;
      `ADDR_LIVE_ZERO: pick = z;
      `ADDR_CHAN_SUMMARY: pick = s;
      `ADDR_OUT_ONE: pick = o1;
      `ADDR_OUT_TWO: pick = o2;
      `ADDR_LIVE_ONE: pick = v1;
      `ADDR_LIVE_TWO: pick = v2;
      default: pick = 8'h00;
    endcase
  endfunction

  logic [7:0] next_rdata;
  logic next_rvalid;
  // writes are ignored entirely: no flag has a write path
  always_comb begin
    next_rvalid = req.rd;
    next_rdata = rdata;
    if (req.rd) begin
      next_rdata = pick(req.addr, latched_one, latched_two, live_zero, live_summary,
                        live_out_one, live_out_two, live_one, live_two);
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= `STATUS_RESET;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_latch_clears: assert property (@(posedge clock) disable iff (!rst_n)
    clr_two && !(|(live_two & 8'hf0)) |=> latched_two == 8'h00)
    else $error("latched two not cleared by read");
  a_voice_latch: assert property (@(posedge clock) disable iff (!rst_n)
    ev.voice_up |=> latched_two[5])
    else $error("voice up not latched");
  a_live_zero_rd: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.addr == `ADDR_LIVE_ZERO |=> rdata == {$past(ev.clock_error),
      $past(ev.pll_lock), 6'h00})
    else $error("live zero readback wrong");
  // checked through the read path so a broken decode or mux is caught too
  a_summary_or: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.addr == `ADDR_CHAN_SUMMARY |=>
      rdata == {2'h0, $past(c1 != 4'h0), $past(c2 != 4'h0), 4'h0})
    else $error("summary mismatch");
  a_out_one_rd: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.addr == `ADDR_OUT_ONE |=> rdata == {$past(c1), 4'h0})
    else $error("channel one fault readback wrong");
  a_out_two_rd: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.addr == `ADDR_OUT_TWO |=> rdata[7:1] == {$past(c2), 3'h0})
    else $error("channel two fault readback wrong");
  a_live_one_rd: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.addr == `ADDR_LIVE_ONE |=> rdata == {4'h0, $past(ev.headset_insert),
      $past(ev.headset_remove), $past(ev.headset_hook), 1'b0})
    else $error("live one readback wrong");
  a_live_two_rd: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.addr == `ADDR_LIVE_TWO |=> rdata == {$past(ev.thresh_upper),
      $past(ev.thresh_lower), $past(ev.voice_up), $past(ev.voice_down), 4'h0})
    else $error("live two readback wrong");
  // reset must clear the read port even if a read was pending
  a_reset_clear: assert property (@(posedge clock)
    !rst_n |=> rdata == `STATUS_RESET && !rvalid)
    else $error("read port not cleared by reset");
  a_rvalid_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    rvalid == $past(req.rd))
    else $error("read answer not one cycle after strobe");
  a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (latched_two[3:0] == 4'h0) && (latched_one[7:4] == 4'h0) && !latched_one[0])
    else $error("reserved latched bit set");
  a_write_inert: assert property (@(posedge clock) disable iff (!rst_n)
    req.wr && !req.rd && !(|(live_one & 8'h0e)) |=> latched_one == $past(latched_one))
    else $error("write changed a flag");
  a_hold_until_rd: assert property (@(posedge clock) disable iff (!rst_n)
    latched_one[3] && !clr_one |=> latched_one[3])
    else $error("headset insert flag lost");
  a_unmapped_zero: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.addr == 7'h3e |=> rdata == 8'h00 && rvalid)
    else $error("unmapped read not zero");
  a_reg_short: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.addr == `ADDR_OUT_TWO |=>
      rdata[3:0] == {3'h0, $past(ev.regulator_short)})
    else $error("regulator short mismatch");
  c_latch_read: cover property (@(posedge clock) disable iff (!rst_n)
    latched_two[7] ##1 clr_two ##1 !latched_two[7]);
  c_set_on_clear: cover property (@(posedge clock) disable iff (!rst_n)
    clr_one && live_one[2]);
  c_chan_fault: cover property (@(posedge clock) disable iff (!rst_n)
    live_summary[5] && live_summary[4]);
  c_unmapped_read: cover property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.addr == 7'h3e);
endmodule // fault_event_status_readback
`default_nettype wire

// File: verification/fault_event_status_readback_tb.sv
// self-checking bench for the fault and event status readback bank
// assumes the design files under logic/ are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "fault_status_params.svh"
module fault_event_status_readback_tb
  import fault_status_pkg::*;
;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  event_src_t events = '0;
  chan_fault_t chan_one = '0;
  chan_fault_t chan_two = '0;
  reg_req_t req = '0;
  logic [7:0] rdata;
  logic rvalid;
  int failures = 0;
  int comparisons = 0;

  // 125 MHz clock
  always #4 clock = ~clock;

  fault_event_status_readback uut (
    .clock(clock), .rst_n(rst_n), .events(events), .chan_one(chan_one),
    .chan_two(chan_two), .req(req), .rdata(rdata), .rvalid(rvalid)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle read strobe, bounded wait for the answer
  task automatic rd(input logic [6:0] addr, input logic [7:0] exp);
    int i;
    req.rd = 1'b1;
    req.addr = addr;
    tick(1);
    req.rd = 1'b0;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++) tick(1);
    if (rvalid !== 1'b1) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, 8'h00, 8'h01);
      results();
    end
    chk(rdata, exp);
    tick(1);
    chk({7'h00, rvalid}, 8'h00);
  endtask

  // writes carry no indication, so just strobe for one cycle
  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    req.wr = 1'b1;
    req.addr = addr;
    req.wdata = data;
    tick(1);
    req.wr = 1'b0;
    req.wdata = 8'h00;
    tick(1);
  endtask

  // all six live views in one go; reserved positions must read zero
  task automatic live(input logic [7:0] z, s, o1, o2, v1, v2);
    rd(`ADDR_LIVE_ZERO, z);
    rd(`ADDR_CHAN_SUMMARY, s);
    rd(`ADDR_OUT_ONE, o1);
    rd(`ADDR_OUT_TWO, o2);
    rd(`ADDR_LIVE_ONE, v1);
    rd(`ADDR_LIVE_TWO, v2);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic sc_reset();
    rd(`ADDR_LATCHED_ONE, 8'h00);
    rd(`ADDR_LATCHED_TWO, 8'h00);
    live(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    rd(7'h3e, 8'h00);
  endtask

  // two patterns, complementary except chan_two; channel two short_pos and vground_pos never go high
  task automatic sc_live();
    // upper, voice up, clock error, insert, hook, regulator short
    events = 10'b1010101011;
    chan_one = 4'b1010;
    chan_two = 4'b0101;
    tick(8);
    live(8'h80, 8'h30, 8'ha0, 8'h51, 8'h0a, 8'ha0);
    // lower, voice down, pll lock, remove
    events = 10'b0101010100;
    chan_one = 4'b0101;
    chan_two = 4'b0000;
    tick(8);
    live(8'h40, 8'h20, 8'h50, 8'h00, 8'h04, 8'h50);
  endtask

  // sources gone: live drops, latched holds until read, writes ignored
  task automatic sc_latched();
    events = '0;
    chan_one = '0;
    tick(8);
    live(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    wr(`ADDR_LATCHED_TWO, 8'h00);
    wr(`ADDR_LATCHED_ONE, 8'h00);
    wr(`ADDR_LIVE_ZERO, 8'hc0);
    tick(2);
    rd(`ADDR_LIVE_ZERO, 8'h00);
    rd(`ADDR_LATCHED_TWO, 8'hf0);
    rd(`ADDR_LATCHED_TWO, 8'h00);
    rd(`ADDR_LATCHED_ONE, 8'h0e);
    rd(`ADDR_LATCHED_ONE, 8'h00);
  endtask

  // a condition still present re-latches right after the clearing read
  task automatic sc_persist();
    events.voice_up = 1'b1;
    tick(8);
    rd(`ADDR_LATCHED_TWO, 8'h20);
    rd(`ADDR_LATCHED_TWO, 8'h20);
    events = '0;
    tick(8);
    rd(`ADDR_LATCHED_TWO, 8'h20);
    rd(`ADDR_LATCHED_TWO, 8'h00);
  endtask

  // reset in mid-run must wipe latched flags and the held read data
  task automatic sc_mid_reset();
    events = 10'b0001000100;
    tick(8);
    rd(`ADDR_LIVE_TWO, 8'h10);
    events = '0;
    tick(8);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(1);
    chk(rdata, 8'h00);
    rd(`ADDR_LATCHED_TWO, 8'h00);
    rd(`ADDR_LATCHED_ONE, 8'h00);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    tick(16);
    rst_n = 1'b1;
    tick(1);
    sc_reset();
    sc_live();
    sc_latched();
    sc_persist();
    sc_mid_reset();
    results();
  end
endmodule // fault_event_status_readback_tb
`default_nettype wire
